//--- rtl/cct_pkg.sv
// package of constants and types for the charge-cycle status timer
package cct_pkg;

  // charge algorithm as decoded from the three-state mode input
  typedef enum logic [1:0] {
    CCT_ALG_CCCV,
    CCT_ALG_LEAD,
    CCT_ALG_CC
  } cct_alg_t;

  // charge-cycle phases
  typedef enum logic [2:0] {
    CCT_ST_IDLE,
    CCT_ST_PRECOND,
    CCT_ST_BULK,
    CCT_ST_ABSORB,
    CCT_ST_FLOAT,
    CCT_ST_DONE
  } cct_state_t;

  // mode input pin codes
  localparam logic [1:0] CCT_MODE_GND  = 2'h0;
  localparam logic [1:0] CCT_MODE_OPEN = 2'h1;
  localparam logic [1:0] CCT_MODE_VCC  = 2'h2;

  // clock rate and timer pacing
  localparam int          CCT_CLK_MHZ     = 200;
  localparam int          CCT_TICK_NS     = 1000;
  localparam int          CCT_TICK_CYC    = (CCT_TICK_NS * CCT_CLK_MHZ) / 1000;
  localparam int          CCT_TICK_W      = 8;
  localparam int          CCT_TMR_W       = 32;
  // default end-of-cycle count in ticks, shortened in simulation
  localparam int          CCT_EOC_TICKS   = 10800;
  // bad-battery tap sits at one eighth of the end-of-cycle count
  localparam int          CCT_TAP_SHIFT   = 3;

  // register map (classic wishbone, 32-bit words)
  localparam logic [7:0]  CCT_ADR_CTRL    = 8'h00;
  localparam logic [7:0]  CCT_ADR_STATUS  = 8'h04;
  localparam logic [7:0]  CCT_ADR_TIMER   = 8'h08;
  localparam logic [7:0]  CCT_ADR_EOC     = 8'h0c;

  // control fields
  localparam int          CCT_CTRL_SHUTDOWN_INPUT   = 0;
  localparam int          CCT_CTRL_W      = 1;
  localparam logic [CCT_CTRL_W-1:0] CCT_CTRL_RST = 1'h1;

  // status fields
  localparam int          CCT_ST_F_STATE  = 0;
  localparam int          CCT_ST_F_ALG    = 4;
  localparam int          CCT_ST_F_BAD    = 8;
  localparam int          CCT_ST_F_STATUS_LINE_ONE  = 9;
  localparam int          CCT_ST_F_STATUS_LINE_TWO  = 10;
  localparam int          CCT_ST_F_TIMED  = 11;

endpackage

//--- rtl/cct_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module cct_sync (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);
  logic meta_q; // first stage, read only by the second

  // plain two-stage capture
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- rtl/cct_tick.sv
// divider making a one-cycle tick enable for the charge timer
`timescale 1ns/1ps
module cct_tick
  import cct_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  output logic      tick
);
  localparam logic [CCT_TICK_W-1:0] LAST = CCT_TICK_W'(CCT_TICK_CYC - 1);

  logic [CCT_TICK_W-1:0] cnt_q; // cycles within one tick period

  // free-running divider, one pulse per period
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule

//--- rtl/cct_core.sv
// charge-cycle sequencer, status lines, timer and wishbone registers
//
// Notes on behaviour
// - termination grounds the soft-start pin
// - bad-battery or thermistor fault grounds soft-start
// - cc/cv: line one on above c/10, thermistor fault
// - cc/cv: line two on for faults only
// - cc/cv: line one off terminated or below c/10
// - cc-only: line one whole cycle; two thermistor
// - lead-acid: line one on bulk and absorption
// - lead-acid: line two on bulk and float
// - on means low; cc-only never off-on pattern
// - timer pin grounded selects c/10 termination
// - c/10 mode cc/cv ends below one tenth
// - lead-acid absorption goes float below c/10
// - c/10 mode cc-only never terminates
// - no bad-battery check in c/10 mode
// - timer starts at cc to cv transition
// - timed cc/cv: keep charging, terminate at expiry
// - lead-acid timer expiry forces float
// - cc-only terminated until power or shutdown cycled
// - precondition past one eighth: bad battery
// - bad battery holds until feedback recovers
// - thermistor fault halts charging, holds timer
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module cct_core
  import cct_pkg::*;
#(
  parameter int EOC_TICKS = CCT_EOC_TICKS
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // analog comparator levels, asynchronous
  input  wire logic [1:0]  charge_mode_pin,
  input  wire logic        timer_pin_grounded,
  input  wire logic        shutdown_input,
  input  wire logic        battery_thermistor_input,
  input  wire logic        feedback_below_precond,
  input  wire logic        current_above_c10,
  input  wire logic        voltage_loop_active,
  // open-drain pins: output always low, enable low means driving
  output logic             current_limit_softstart_pin_o,
  output logic             current_limit_softstart_pin_oe_n,
  output logic             status_line_one_o,
  output logic             status_line_one_oe_n,
  output logic             status_line_two_o,
  output logic             status_line_two_oe_n,
  // charger power stage controls
  output logic             charge_enable,
  output logic             battery_connect
);

  localparam logic [CCT_TMR_W-1:0] EOC = CCT_TMR_W'(EOC_TICKS);
  localparam logic [CCT_TMR_W-1:0] TAP = EOC >> CCT_TAP_SHIFT;

  // ---- synchronised pin levels ----
  logic [1:0] mode_s;    // mode pin code
  logic       tgnd_s;    // timer pin shorted
  logic       shutdown_input_s;    // shutdown pin
  logic       ntc_s;     // thermistor fault level
  logic       pre_s;     // feedback below precondition level
  logic       c10_s;     // current above one tenth
  logic       cv_s;      // voltage loop in control
  logic       tick;      // timer pacing enable

  logic [7:0] raw;
  logic [7:0] syn;
  assign raw = {charge_mode_pin, timer_pin_grounded, shutdown_input,
                battery_thermistor_input, feedback_below_precond,
                current_above_c10, voltage_loop_active};
  assign {mode_s, tgnd_s, shutdown_input_s, ntc_s, pre_s, c10_s, cv_s} = syn;

  // one synchroniser per asynchronous level
  for (genvar i = 0; i < 8; i++) begin : g_sync
    cct_sync u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .d      (raw[i]),
      .q      (syn[i])
    );
  end

  cct_tick u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (tick)
  );

  // ---- whole state of the block ----
  typedef struct packed {
    cct_state_t             st;      // charge phase
    cct_alg_t               alg;     // latched algorithm
    logic                   timed;   // latched timer termination
    logic [CCT_TMR_W-1:0]   tmr;     // end-of-cycle count
    logic                   trun;    // timer started
    logic [CCT_TMR_W-1:0]   ptmr;    // precondition watch count
    logic                   bad;     // bad-battery fault
    logic                   s1;      // status one on
    logic                   s2;      // status two on
    logic                   ss_gnd;  // soft-start grounded
    logic                   chg;     // charging enabled
    logic                   conn;    // battery connected
    logic [CCT_CTRL_W-1:0]  ctrl;    // software shutdown bit
    logic                   ack;     // bus acknowledge
    logic [31:0]            rdat;    // bus read data
  } cct_core_t;

  cct_core_t s_q;
  cct_core_t s_d;

  // decoded mode pin, open and unknown codes mean cc-only
  function automatic cct_alg_t decode_mode(input logic [1:0] m);
    cct_alg_t a;
    a = CCT_ALG_CC;
    if (m == CCT_MODE_GND) begin
      a = CCT_ALG_CCCV;
    end else if (m == CCT_MODE_VCC) begin
      a = CCT_ALG_LEAD;
    end
    return a;
  endfunction

  logic off;      // hardware or software shutdown
  logic halt;     // fault halts charging
  logic expire;   // timer reached end of cycle
  logic req;      // bus request this cycle
  logic [31:0] rd_mux;

  assign off    = shutdown_input_s | s_q.ctrl[CCT_CTRL_SHUTDOWN_INPUT];
  assign expire = s_q.timed && s_q.trun && (s_q.tmr >= EOC);
  assign halt   = ntc_s | s_q.bad;
  assign req    = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      CCT_ADR_CTRL:   rd_mux[CCT_CTRL_W-1:0] = s_q.ctrl;
      CCT_ADR_STATUS: begin
        rd_mux[CCT_ST_F_STATE +: 3] = s_q.st;
        rd_mux[CCT_ST_F_ALG +: 2]   = s_q.alg;
        rd_mux[CCT_ST_F_BAD]        = s_q.bad;
        rd_mux[CCT_ST_F_STATUS_LINE_ONE]      = s_q.s1;
        rd_mux[CCT_ST_F_STATUS_LINE_TWO]      = s_q.s2;
        rd_mux[CCT_ST_F_TIMED]      = s_q.timed;
      end
      CCT_ADR_TIMER:  rd_mux = s_q.tmr;
      CCT_ADR_EOC:    rd_mux = EOC;
      default:        rd_mux = '0;
    endcase
  end

  // next-state logic
  always_comb begin
    s_d     = s_q;
    s_d.ack = req;
    if (req) begin
      s_d.rdat = rd_mux;
    end
    // software shutdown bit, byte lane zero
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == CCT_ADR_CTRL) begin
      s_d.ctrl = wb_dat_i[CCT_CTRL_W-1:0];
    end

    // bad battery clears once feedback recovers
    if (s_q.bad && !pre_s) begin
      s_d.bad = 1'b0;
    end

    // precondition watch: counts ticks below threshold
    if (s_q.st == CCT_ST_PRECOND && tick && !ntc_s) begin
      s_d.ptmr = s_q.ptmr + 1'b1;
    end
    // only timed cc/cv and lead-acid watch for bad battery
    if (s_q.timed && s_q.alg != CCT_ALG_CC &&
        s_q.st == CCT_ST_PRECOND && s_q.ptmr >= TAP) begin
      s_d.bad = 1'b1;
    end

    // timer runs on ticks, held during thermistor faults
    if (s_q.trun && tick && !ntc_s && !expire) begin
      s_d.tmr = s_q.tmr + 1'b1;
    end

    unique case (s_q.st)
      CCT_ST_IDLE: begin
        // latch configuration at cycle start
        s_d.alg   = decode_mode(mode_s);
        s_d.timed = !tgnd_s;
        s_d.tmr   = '0;
        s_d.ptmr  = '0;
        s_d.trun  = 1'b0;
        if (!off) begin
          s_d.st = pre_s ? CCT_ST_PRECOND : CCT_ST_BULK;
        end
      end
      CCT_ST_PRECOND: begin
        if (!pre_s) begin
          s_d.st = CCT_ST_BULK;
        end
      end
      CCT_ST_BULK: begin
        if (pre_s) begin
          s_d.st = CCT_ST_PRECOND;
        end else if (cv_s && !ntc_s) begin
          s_d.st   = CCT_ST_ABSORB;
          s_d.trun = s_q.timed;
        end
      end
      CCT_ST_ABSORB: begin
        if (pre_s) begin
          s_d.st = CCT_ST_PRECOND;
        end else if (s_q.alg == CCT_ALG_LEAD) begin
          if (!c10_s || expire) begin
            s_d.st   = CCT_ST_FLOAT;
            s_d.trun = 1'b0;
          end
        end else if (s_q.timed) begin
          if (expire) begin
            s_d.st = CCT_ST_DONE;
          end
        end else if (s_q.alg == CCT_ALG_CCCV && !c10_s) begin
          s_d.st = CCT_ST_DONE;
        end
        // untimed cc-only stays here for ever
      end
      CCT_ST_FLOAT: begin
        s_d.st = CCT_ST_FLOAT;
      end
      CCT_ST_DONE: begin
        // only a shutdown cycle restarts a finished cycle
        s_d.st = CCT_ST_DONE;
      end
    endcase

    // shutdown resets the cycle from any phase
    if (off) begin
      s_d.st   = CCT_ST_IDLE;
      s_d.bad  = 1'b0;
      s_d.trun = 1'b0;
    end

    // soft-start grounded when not charging or faulted
    s_d.ss_gnd = (s_d.st == CCT_ST_IDLE) ||
                 (s_d.st == CCT_ST_DONE) || ntc_s || s_d.bad;

    s_d.chg  = (s_d.st != CCT_ST_IDLE) &&
               (s_d.st != CCT_ST_DONE) && !ntc_s && !s_d.bad;
    s_d.conn = (s_d.st != CCT_ST_DONE);

    // status encoding per algorithm
    s_d.s1 = 1'b0;
    s_d.s2 = 1'b0;
    if (s_d.st != CCT_ST_IDLE) begin
      unique case (s_d.alg)
        CCT_ALG_CCCV: begin
          s_d.s1 = ntc_s || (!s_d.bad &&
                   s_d.st != CCT_ST_DONE && c10_s);
          s_d.s2 = ntc_s || s_d.bad;
        end
        CCT_ALG_CC: begin
          s_d.s1 = ntc_s || s_d.st != CCT_ST_DONE;
          s_d.s2 = ntc_s && s_d.s1;
        end
        CCT_ALG_LEAD: begin
          if (!ntc_s && !s_d.bad) begin
            s_d.s1 = s_d.st != CCT_ST_FLOAT;
            s_d.s2 = s_d.st != CCT_ST_ABSORB;
          end
        end
        default: begin
          s_d.s1 = 1'b0;
          s_d.s2 = 1'b0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.st    <= CCT_ST_IDLE;
      s_q.alg   <= CCT_ALG_CCCV;
      s_q.ss_gnd <= 1'b1;
      s_q.ctrl  <= CCT_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // pins: on means driven low, enable active low
  assign current_limit_softstart_pin_o    = 1'b0;
  assign current_limit_softstart_pin_oe_n = ~s_q.ss_gnd;
  assign status_line_one_o                = 1'b0;
  assign status_line_one_oe_n             = ~s_q.s1;
  assign status_line_two_o                = 1'b0;
  assign status_line_two_oe_n             = ~s_q.s2;
  assign charge_enable                    = s_q.chg;
  assign battery_connect                  = s_q.conn;
  assign wb_ack_o                         = s_q.ack;
  assign wb_dat_o                         = s_q.rdat;

endmodule

//--- tb/cct_status_mon.sv
// status-line monitor: pull-ups on both open-drain lines
`timescale 1ns/1ps
module cct_status_mon (
  input  wire logic one_o,
  input  wire logic one_oe_n,
  input  wire logic two_o,
  input  wire logic two_oe_n,
  output logic      one_on,
  output logic      two_on
);
  // released line floats up, so on means pulled low
  assign one_on = !(one_oe_n ? 1'b1 : one_o);
  assign two_on = !(two_oe_n ? 1'b1 : two_o);
endmodule

//--- tb/cct_core_props.sv
// checker for bus handshake and pin relations of the charge block
`timescale 1ns/1ps
module cct_core_props
  import cct_pkg::*;
#(
  parameter int EOC_TICKS = CCT_EOC_TICKS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic shutdown_input,
  input wire logic battery_thermistor_input,
  input wire logic charge_enable,
  input wire logic current_limit_softstart_pin_oe_n,
  input wire logic status_line_one_oe_n,
  input wire logic status_line_two_oe_n,
  input wire logic status_line_one_o,
  input wire logic status_line_two_o
);
  // single domain, reset gates every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // a request taken while idle is answered next cycle
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  drain_low_a:
    assert property (!status_line_one_o && !status_line_two_o)
    else $error("status line drives high");
  softstart_idle_a:
    assert property (!charge_enable |-> !current_limit_softstart_pin_oe_n)
    else $error("soft-start released while halted");
  // five samples leave room for the synchroniser lag
  therm_halt_a:
    assert property (battery_thermistor_input [*5] |->
      !charge_enable && !current_limit_softstart_pin_oe_n)
    else $error("charging during thermistor fault");
  shutdown_input_off_a:
    assert property (shutdown_input [*5] |->
      status_line_one_oe_n && status_line_two_oe_n && !charge_enable)
    else $error("status shown in shutdown");
  start_release_a:
    assert property ($rose(charge_enable) |-> !$past(shutdown_input, 2))
    else $error("charging started under shutdown");
  cover property (battery_thermistor_input && !charge_enable);
  cover property ($fell(charge_enable));
  cover property ($rose(wb_ack_o));
endmodule

bind cct_core cct_core_props #(.EOC_TICKS(EOC_TICKS)) cct_core_props_inst (.*);

//--- tb/test_charge_cycle_status_timer.sv
// bench for the charge block: phases, status lines and registers
`timescale 1ns/1ps
module test_charge_cycle_status_timer;
  import cct_pkg::*;
  localparam int EOC = 16;              // short end-of-cycle count
  localparam int LNG = (EOC + 2) * 200; // outlasts one timer run
  logic        mclk, resetn, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [31:0] dat, rdo, rd;
  logic [1:0]  mode;
  logic        tmr, sd, thr, fb, cur, vl, bc, ce;
  logic        ss_o, ss_n, s1_o, s1_n, s2_o, s2_n, s1, s2;
  int          n_mismatch = 0, n_checks = 0, seed = 37, alg = 0;

  cct_core #(.EOC_TICKS(EOC)) cct_core_inst (
    .mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .charge_mode_pin(mode),
    .timer_pin_grounded(tmr), .shutdown_input(sd),
    .battery_thermistor_input(thr), .feedback_below_precond(fb),
    .current_above_c10(cur), .voltage_loop_active(vl),
    .current_limit_softstart_pin_o(ss_o),
    .current_limit_softstart_pin_oe_n(ss_n),
    .status_line_one_o(s1_o), .status_line_one_oe_n(s1_n),
    .status_line_two_o(s2_o), .status_line_two_oe_n(s2_n),
    .charge_enable(ce), .battery_connect(bc));
  cct_status_mon cct_status_mon_inst (
    .one_o(s1_o), .one_oe_n(s1_n), .two_o(s2_o), .two_oe_n(s2_n),
    .one_on(s1), .two_on(s2));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(n < 100), 32'h1);
  endtask

  // expected {line one, line two, charging, soft-start grounded}
  function automatic logic [3:0] mdl(int ph, logic t, logic b, logic c);
    logic act, run, l1, l2;
    act = ph >= 1 && ph <= 4;
    run = act && !t && !b;
    case (alg)
      0: begin
        l1 = act && (t || c && !b);
        l2 = act && (t || b);
      end
      1: begin
        l1 = run && ph inside {2, 3};
        l2 = run && ph inside {2, 4};
      end
      default: begin
        l1 = act;
        l2 = act && t;
      end
    endcase
    return {l1, l2, run, !run};
  endfunction

  // p = {timer grounded, shutdown, thermistor, low feedback, current, cv}
  task automatic st(input logic [1:0] m, input logic [5:0] p, input int w,
                    input int ph, input logic b);
    @(posedge mclk);
    mode <= m;
    {tmr, sd, thr, fb, cur, vl} <= p;
    // algorithm only latched while idle
    if (p[4])
      alg = (m == 2'h0) ? 0 : (m == 2'h2) ? 1 : 2;
    repeat (w) @(posedge mclk);
    #1;
    chk({s1, s2, ce, !ss_n}, mdl(ph, p[3], b, p[1]));
    // battery stays connected except after termination, timed or c/10
    chk(32'(bc), 32'(ph != 5));
    wb(1'b0, CCT_ADR_STATUS, 32'h0);
    if (!p[3] && !b)
      chk(rd[2:0], ph[2:0]);
  endtask

  initial begin
    resetn = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    mode = 2'h0;
    {tmr, sd, thr, fb, cur, vl} = 6'b010000;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, CCT_ADR_CTRL, 32'h0);
    chk(rd, 32'(CCT_CTRL_RST));
    wb(1'b0, CCT_ADR_EOC, 32'h0);
    chk(rd, EOC);
    wb(1'b1, 8'h10, $random(seed));
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, CCT_ADR_CTRL, 32'h0);
    wb(1'b0, CCT_ADR_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    st(2'h0, 6'b010000, 8, 0, 0);
    st(2'h0, 6'b000010, 10, 2, 0);
    st(2'h0, 6'b000000, LNG, 2, 0);
    st(2'h0, 6'b000011, 10, 3, 0);
    st(2'h0, 6'b001011, LNG, 3, 0);
    st(2'h0, 6'b000011, 10, 3, 0);
    st(2'h0, 6'b000011, LNG, 5, 0);
    st(2'h0, 6'b110000, 8, 0, 0);
    st(2'h0, 6'b100010, 10, 2, 0);
    st(2'h0, 6'b100001, 20, 5, 0);
    $display("test cc/cv done");
    st(2'h0, 6'b010000, 8, 0, 0);
    st(2'h0, 6'b000110, 10, 1, 0);
    st(2'h0, 6'b000110, LNG/4, 1, 1);
    st(2'h0, 6'b000010, 10, 2, 0);
    st(2'h0, 6'b110000, 8, 0, 0);
    st(2'h0, 6'b100110, LNG/4, 1, 0);
    $display("test bad battery done");
    st(2'h2, 6'b110000, 8, 0, 0);
    st(2'h2, 6'b100010, 10, 2, 0);
    st(2'h2, 6'b100011, 10, 3, 0);
    st(2'h2, 6'b100001, 20, 4, 0);
    st(2'h2, 6'b101001, 10, 4, 0);
    st(2'h2, 6'b010000, 8, 0, 0);
    st(2'h2, 6'b000011, 20, 3, 0);
    st(2'h2, 6'b000011, LNG, 4, 0);
    $display("test lead-acid done");
    st(2'h1, 6'b110000, 8, 0, 0);
    st(2'h1, 6'b100010, 10, 2, 0);
    st(2'h0, 6'b100000, LNG, 2, 0);
    st(2'h0, 6'b101000, 10, 2, 0);
    st(2'h3, 6'b010000, 8, 0, 0);
    st(2'h3, 6'b000011, LNG, 5, 0);
    st(2'h3, 6'b000010, LNG, 5, 0);
    st(2'h3, 6'b010000, 8, 0, 0);
    st(2'h3, 6'b000010, 10, 2, 0);
    $display("test cc-only done");
    summarize();
  end

  // hang guard, well beyond the planned run
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule
